// ### core/vhp_defines.svh
`ifndef VHP_DEFINES_SVH
`define VHP_DEFINES_SVH

// ---------------------------------------------------------------------
// Command decode
// ---------------------------------------------------------------------
`define VHP_OP_HI          7
`define VHP_OP_LO          6
`define VHP_ADDR_HI_MSB    5
`define VHP_REGCMD_HI      7
`define VHP_REGCMD_LO      4
`define VHP_REGCMD_CODE    4'h8
`define VHP_REGNUM_MAX     4'hA
`define VHP_CRAM_ADDR_MSB  4
`define VHP_CRAM_DATA_MSB  5
`define VHP_CRAM_DEPTH     32
`define VHP_VRAM_AW        14

// ---------------------------------------------------------------------
// Register numbers
// ---------------------------------------------------------------------
`define VHP_REG_MODE_A     4'h0
`define VHP_REG_MODE_B     4'h1
`define VHP_REG_MAP_BASE   4'h2
`define VHP_REG_FIXED3     4'h3
`define VHP_REG_FIXED4     4'h4
`define VHP_REG_SPR_BASE   4'h5

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define VHP_RST_MODE_A     8'h36
`define VHP_RST_MODE_B     8'hA0
`define VHP_RST_ONES       8'hFF

// ---------------------------------------------------------------------
// Register fields
// ---------------------------------------------------------------------
`define VHP_A_VLOCK        7
`define VHP_A_HLOCK        6
`define VHP_A_LBLANK       5
`define VHP_A_LINE_IE      4
`define VHP_A_SHIFT        3
`define VHP_A_EXTSYNC      0
`define VHP_B_DISP_ON      6
`define VHP_B_VB_IE        5
`define VHP_B_TALL         1
`define VHP_MAP_HI         3
`define VHP_MAP_LO         1
`define VHP_SPR_HI         6
`define VHP_SPR_LO         1

`endif

// ### core/vhp_pkg.sv
package vhp_pkg;
   // Operation field of the second command byte
   typedef enum logic [1:0] {
      VHP_OP_VRAM_RD = 2'b00,
      VHP_OP_VRAM_WR = 2'b01,
      VHP_OP_REG_WR  = 2'b10,
      VHP_OP_CRAM_WR = 2'b11
   } vhp_op_t;

   // Target of data-port traffic after the last command
   typedef enum logic [1:0] {
      VHP_TGT_VRAM_RD = 2'b00,
      VHP_TGT_VRAM_WR = 2'b01,
      VHP_TGT_CRAM    = 2'b10,
      VHP_TGT_NONE    = 2'b11
   } vhp_tgt_t;
endpackage

// ### core/vhp_host_port.sv
`timescale 1ns/10ps
`include "vhp_defines.svh"
// Summary of operation
// R01: second byte bits 7:6 select operation
// R02: host writes command bytes in pairs
// R03: video RAM address from both command bytes
// R04: data port access increments video address
// R05: host reissues command on direction change
// R06: register write: 1000, number, value byte
// R07: register updates on second byte alone
// R08: control registers cannot be read back
// R09: colour address five bits in first byte
// R10: colour value holds 2-bit blue, green, red
// R11: colour writes increment colour address
// R12: colour RAM forms two sixteen-colour banks
// R13: status read returns and clears requests
// R14: mode A bit 7 locks right columns
// R15: mode A bit 6 locks top rows
// R16: mode A bit 5 blanks left column
// R17: mode A bit 3 shifts sprites left
// R18: mode B bit 6 turns display on
// R19: mode B bit 1 selects tall sprites
// R20: two enable bits gate the two interrupts
// R21: host programs the fixed bits correctly
// R22: map base bits 3:1 give address 13:11
// R23: host loads registers three, four all ones
// R24: sprite table base bits 6:1 give 13:8
// R25: command byte phase flag toggles per write
// R26: data accesses queued, serviced in slots
module vhp_host_port
   import vhp_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        cmd_wr_i,
   input  wire logic        cmd_rd_i,
   input  wire logic        data_wr_i,
   input  wire logic        data_rd_i,
   input  wire logic [7:0]  host_data_i,
   output logic      [7:0]  host_data_o,
   input  wire logic        vblank_evt_i,
   input  wire logic        line_evt_i,
   input  wire logic        mem_slot_i,
   input  wire logic [7:0]  vram_rdata_i,
   output logic      [13:0] vram_addr_o,
   output logic      [7:0]  vram_wdata_o,
   output logic             vram_we_o,
   output logic             vram_re_o,
   input  wire logic [4:0]  cram_raddr_i,
   output logic      [5:0]  cram_rdata_o,
   output logic             right_columns_vscroll_lock_o,
   output logic             top_rows_hscroll_lock_o,
   output logic             left_column_blanking_o,
   output logic             sprite_shift_o,
   output logic             external_sync_select_o,
   output logic             display_on_o,
   output logic             sprite_tall_select_o,
   output logic      [13:0] screen_map_base_o,
   output logic      [13:0] sprite_table_base_o,
   output logic             irq_n_o
);

   // ---------------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------------
   logic [7:0]  display_mode_control_a;
   logic [7:0]  display_mode_control_b;
   logic [7:0]  screen_map_base;
   logic [7:0]  fixed_ones_reg_three;
   logic [7:0]  fixed_ones_reg_four;
   logic [7:0]  sprite_table_base;
   logic        second_phase;
   logic [7:0]  first_byte;
   logic [13:0] vram_addr;
   logic [4:0]  cram_addr;
   vhp_tgt_t    target;
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  wr_byte;
   logic [7:0]  rd_buf;
   logic        vblank_req;
   logic        line_req;
   logic [5:0]  cram_mem [`VHP_CRAM_DEPTH];

   // ---------------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------------
   wire         pair_done  = cmd_wr_i & second_phase;
   wire vhp_op_t op        = vhp_op_t'(host_data_i[`VHP_OP_HI:`VHP_OP_LO]); // see R01
   wire [3:0]   reg_num    = host_data_i[3:0];
   wire         reg_ok     = (host_data_i[`VHP_REGCMD_HI:`VHP_REGCMD_LO] == `VHP_REGCMD_CODE)
                             && (reg_num <= `VHP_REGNUM_MAX); // see R06
   wire         do_reg_wr  = pair_done && (op == VHP_OP_REG_WR) && reg_ok; // see R07
   wire         do_vram    = pair_done && !op[1];
   wire         do_cram    = pair_done && (op == VHP_OP_CRAM_WR);
   wire [13:0]  cmd_vaddr  = {host_data_i[`VHP_ADDR_HI_MSB:0], first_byte}; // see R03
   wire         cram_wr    = data_wr_i && (target == VHP_TGT_CRAM);
   wire         vram_wr_in = data_wr_i && (target == VHP_TGT_VRAM_WR);
   wire         vram_rd_in = data_rd_i && (target == VHP_TGT_VRAM_RD);
   // A slot serves a queued write, or refills the read buffer
   wire         slot_wr    = mem_slot_i && wr_pend;
   wire         slot_rd    = mem_slot_i && !wr_pend && rd_pend;
   wire         status_rd  = cmd_rd_i;
   wire         next_vb    = vblank_evt_i | (vblank_req & ~status_rd);
   wire         next_line  = line_evt_i | (line_req & ~status_rd);
   // Interrupt enabled per pattern: line needs A bit 4, vblank needs B bit 5
   wire         irq_act    = (line_req & display_mode_control_a[`VHP_A_LINE_IE])
                           | (vblank_req & display_mode_control_b[`VHP_B_VB_IE]); // see R20

   // ---------------------------------------------------------------------
   // Command byte phase
   // ---------------------------------------------------------------------
   // A status read does not break the pair; host guards that itself
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         second_phase <= 1'b0;
         first_byte   <= 8'h00;
      end else if (cmd_wr_i) begin
         second_phase <= ~second_phase; // see R25
         if (!second_phase) begin
            first_byte <= host_data_i; // see R02
         end
      end
   end

   // ---------------------------------------------------------------------
   // Control registers, write only
   // ---------------------------------------------------------------------
   // Nothing below feeds host_data_o, so they never read back
   always_ff @(posedge clk_i) begin // see R08
      if (!nrst_i) begin
         display_mode_control_a <= `VHP_RST_MODE_A;
         display_mode_control_b <= `VHP_RST_MODE_B;
         screen_map_base        <= `VHP_RST_ONES;
         fixed_ones_reg_three   <= `VHP_RST_ONES;
         fixed_ones_reg_four    <= `VHP_RST_ONES;
         sprite_table_base      <= `VHP_RST_ONES;
      end else if (do_reg_wr) begin
         case (reg_num)
            `VHP_REG_MODE_A:   display_mode_control_a <= first_byte; // see R06
            `VHP_REG_MODE_B:   display_mode_control_b <= first_byte;
            `VHP_REG_MAP_BASE: screen_map_base        <= first_byte;
            `VHP_REG_FIXED3:   fixed_ones_reg_three   <= first_byte; // see R23
            `VHP_REG_FIXED4:   fixed_ones_reg_four    <= first_byte;
            `VHP_REG_SPR_BASE: sprite_table_base      <= first_byte;
            default:           ;
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Data port target and addresses
   // ---------------------------------------------------------------------
   // Read prefetch starts at the new address right after the command
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         target    <= VHP_TGT_NONE;
         vram_addr <= 14'h0000;
         cram_addr <= 5'h00;
         rd_pend   <= 1'b0;
      end else if (do_vram) begin
         target    <= (op == VHP_OP_VRAM_WR) ? VHP_TGT_VRAM_WR : VHP_TGT_VRAM_RD;
         vram_addr <= cmd_vaddr; // see R03
         rd_pend   <= (op == VHP_OP_VRAM_RD); // see R05
      end else if (do_cram) begin
         target    <= VHP_TGT_CRAM;
         cram_addr <= first_byte[`VHP_CRAM_ADDR_MSB:0]; // see R09
      end else begin
         if (cram_wr) begin
            cram_addr <= cram_addr + 5'h01; // see R11
         end
         if (slot_wr || slot_rd) begin
            vram_addr <= vram_addr + 14'h0001; // see R04
         end
         if (vram_rd_in) begin
            rd_pend <= 1'b1; // see R26
         end else if (slot_rd) begin
            rd_pend <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Write queue and read buffer
   // ---------------------------------------------------------------------
   // One-deep queue: host spacing guarantees a slot between accesses
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wr_pend <= 1'b0;
         wr_byte <= 8'h00;
         rd_buf  <= 8'h00;
      end else begin
         if (vram_wr_in) begin
            wr_pend <= 1'b1; // see R26
            wr_byte <= host_data_i;
         end else if (slot_wr || do_vram || do_cram) begin
            wr_pend <= 1'b0;
         end
         // Read data follows the registered address, so take it with the read strobe
         if (vram_re_o) begin
            rd_buf <= vram_rdata_i;
         end
      end
   end

   // Memory request outputs, registered; address is the pending one
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         vram_addr_o  <= 14'h0000;
         vram_wdata_o <= 8'h00;
         vram_we_o    <= 1'b0;
         vram_re_o    <= 1'b0;
      end else begin
         vram_addr_o  <= vram_addr;
         vram_wdata_o <= wr_byte;
         vram_we_o    <= slot_wr && !do_vram;
         vram_re_o    <= slot_rd && !do_vram;
      end
   end

   // ---------------------------------------------------------------------
   // Colour RAM
   // ---------------------------------------------------------------------
   // Bank is address bit 4; the renderer picks it from its colour code
   always_ff @(posedge clk_i) begin
      if (cram_wr) begin
         cram_mem[cram_addr] <= host_data_i[`VHP_CRAM_DATA_MSB:0]; // see R10 see R12
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cram_rdata_o <= 6'h00;
      end else begin
         cram_rdata_o <= cram_mem[cram_raddr_i]; // see R12
      end
   end

   // ---------------------------------------------------------------------
   // Interrupt requests and host read data
   // ---------------------------------------------------------------------
   // New event in the clearing cycle survives the clear
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         vblank_req  <= 1'b0;
         line_req    <= 1'b0;
         irq_n_o     <= 1'b1;
         host_data_o <= 8'h00;
      end else begin
         vblank_req <= next_vb; // see R13
         line_req   <= next_line;
         irq_n_o    <= ~irq_act;
         if (status_rd) begin
            host_data_o <= {vblank_req, line_req, 6'h00}; // see R13
         end else if (data_rd_i) begin
            host_data_o <= rd_buf;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Display settings to the renderer
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         right_columns_vscroll_lock_o <= 1'b0;
         top_rows_hscroll_lock_o      <= 1'b0;
         left_column_blanking_o       <= 1'b0;
         sprite_shift_o               <= 1'b0;
         external_sync_select_o       <= 1'b0;
         display_on_o                 <= 1'b0;
         sprite_tall_select_o         <= 1'b0;
         screen_map_base_o            <= 14'h0000;
         sprite_table_base_o          <= 14'h0000;
      end else begin
         right_columns_vscroll_lock_o <= display_mode_control_a[`VHP_A_VLOCK]; // see R14
         top_rows_hscroll_lock_o      <= display_mode_control_a[`VHP_A_HLOCK]; // see R15
         left_column_blanking_o       <= display_mode_control_a[`VHP_A_LBLANK]; // see R16
         sprite_shift_o               <= display_mode_control_a[`VHP_A_SHIFT]; // see R17
         // Fixed bits are passed on as written; host keeps them right
         external_sync_select_o       <= display_mode_control_a[`VHP_A_EXTSYNC]; // see R21
         display_on_o                 <= display_mode_control_b[`VHP_B_DISP_ON]; // see R18
         sprite_tall_select_o         <= display_mode_control_b[`VHP_B_TALL]; // see R19
         screen_map_base_o   <= {screen_map_base[`VHP_MAP_HI:`VHP_MAP_LO], 11'h000}; // see R22
         sprite_table_base_o <= {sprite_table_base[`VHP_SPR_HI:`VHP_SPR_LO], 8'h00}; // see R24
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   // Map base write, then the aligned base two edges later
   sequence s_map_write;
      do_reg_wr && (reg_num == `VHP_REG_MAP_BASE);
   endsequence

   sequence s_map_shown;
      screen_map_base_o == {$past(first_byte[`VHP_MAP_HI:`VHP_MAP_LO], 2), 11'h000};
   endsequence

   a_phase_toggle: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R25
      cmd_wr_i |=> (second_phase != $past(second_phase)))
      else $error("command phase did not toggle");

   a_reg_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R07
      (do_reg_wr && reg_num == `VHP_REG_MODE_B) |=> (display_mode_control_b == $past(first_byte)))
      else $error("register write lost");

   a_vram_load: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R03
      do_vram |=> (vram_addr == $past(cmd_vaddr)))
      else $error("video address not loaded");

   a_vram_incr: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R04
      (slot_wr && !do_vram && !do_cram) |=> (vram_addr == $past(vram_addr) + 14'h0001))
      else $error("video address not advanced");

   a_cram_incr: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R11
      (cram_wr && !do_vram && !do_cram) |=> (cram_addr == $past(cram_addr) + 5'h01))
      else $error("colour address not advanced");

   a_status_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R13
      (status_rd && !line_evt_i && !vblank_evt_i) |=> (!line_req && !vblank_req))
      else $error("status read did not clear");

   a_irq_gate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R20
      (line_req && display_mode_control_a[`VHP_A_LINE_IE]) |=> !irq_n_o)
      else $error("enabled line request gave no interrupt");

   a_map_base: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R22
      s_map_write |-> ##2 s_map_shown)
      else $error("map base not aligned");

   // A malformed register command must leave mode register A alone
   a_reg_refused: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R06
      (pair_done && (op == VHP_OP_REG_WR) && !reg_ok) |=> $stable(display_mode_control_a))
      else $error("refused register write took effect");

   // Status byte carries the requests as they stood when read
   a_status_byte: assert property (@(posedge clk_i) disable iff (!nrst_i) // see R13
      status_rd |=> (host_data_o == {$past(vblank_req), $past(line_req), 6'h00}))
      else $error("status byte wrong");

endmodule // vhp_host_port

// ### verification/vhp_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// Host processor and video memory stand-in
// ---------------------------------------------------------------------
module vhp_host_model (
   input  wire logic        clk_i,
   output logic             cmd_wr_o,
   output logic             cmd_rd_o,
   output logic             data_wr_o,
   output logic             data_rd_o,
   output logic      [7:0]  host_data_o,
   input  wire logic [7:0]  host_rdata_i,
   output logic             mem_slot_o,
   input  wire logic [13:0] vram_addr_i,
   input  wire logic [7:0]  vram_wdata_i,
   input  wire logic        vram_we_i,
   output logic      [7:0]  vram_rdata_o
);
   logic [7:0] mem [0:16383];
   logic [1:0] slot_cnt;
   logic [3:0] strb;

   // Pattern derived from the address so every read has a known answer
   initial begin
      for (int i = 0; i < 16384; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      strb        = 4'h0;
      host_data_o = 8'hA5;
      slot_cnt    = 2'h0;
   end

   // One slot in four, so queued accesses really have to wait
   always @(posedge clk_i) begin
      slot_cnt <= slot_cnt + 2'h1;
      if (vram_we_i) begin
         mem[vram_addr_i] <= vram_wdata_i;
      end
   end

   assign mem_slot_o   = (slot_cnt == 2'h0);
   assign vram_rdata_o = mem[vram_addr_i];
   assign {data_rd_o, data_wr_o, cmd_rd_o, cmd_wr_o} = strb;

   // Kind 0 command, 1 status, 2 data write, 3 data read; idle gap keeps a slot between
   task automatic access(input int kind, input logic [7:0] b, output logic [7:0] rd);
      @(posedge clk_i);
      strb        <= 4'(1 << kind);
      host_data_o <= b;
      @(posedge clk_i);
      strb        <= 4'h0;
      host_data_o <= ~b;   // Released bus shows a changed value
      @(posedge clk_i);
      rd = host_rdata_i;
      repeat (8) @(posedge clk_i);
   endtask

   // Command bytes always go out as a pair
   task automatic cmd_pair(input logic [7:0] b1, input logic [7:0] b2);
      logic [7:0] d;
      access(0, b1, d);
      access(0, b2, d);
   endtask
endmodule // vhp_host_model

// ### verification/vhp_host_port_tb_top.sv
`timescale 1ns/10ps
module vhp_host_port_tb_top;
   logic        clk_i, nrst_i, cmd_wr, cmd_rd, data_wr, data_rd, vblank_evt, line_evt;
   logic        mem_slot, vram_we, vram_re, irq_n;
   logic [7:0]  hd_w, hd_r, vram_rdata, vram_wdata;
   logic [13:0] vram_addr, map_base, spr_base;
   logic [4:0]  cram_raddr;
   logic [5:0]  cram_rdata;
   wire  [6:0]  mode_bits;
   int          err_total = 0;
   int          comparisons = 0;
   int          cyc = 0;

   // ------------------------------------------------------------------
   // Clock, design and partner
   // ------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   vhp_host_port vhp_host_port_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
      .data_wr_i(data_wr), .data_rd_i(data_rd), .host_data_i(hd_w), .host_data_o(hd_r),
      .vblank_evt_i(vblank_evt), .line_evt_i(line_evt), .mem_slot_i(mem_slot),
      .vram_rdata_i(vram_rdata), .vram_addr_o(vram_addr), .vram_wdata_o(vram_wdata),
      .vram_we_o(vram_we), .vram_re_o(vram_re), .cram_raddr_i(cram_raddr),
      .cram_rdata_o(cram_rdata), .right_columns_vscroll_lock_o(mode_bits[6]),
      .top_rows_hscroll_lock_o(mode_bits[5]), .left_column_blanking_o(mode_bits[4]),
      .sprite_shift_o(mode_bits[3]), .external_sync_select_o(mode_bits[2]),
      .display_on_o(mode_bits[1]), .sprite_tall_select_o(mode_bits[0]),
      .screen_map_base_o(map_base), .sprite_table_base_o(spr_base), .irq_n_o(irq_n));

   vhp_host_model vhp_host_model_inst (
      .clk_i(clk_i), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd), .data_wr_o(data_wr),
      .data_rd_o(data_rd), .host_data_o(hd_w), .host_rdata_i(hd_r), .mem_slot_o(mem_slot),
      .vram_addr_i(vram_addr), .vram_wdata_i(vram_wdata), .vram_we_i(vram_we),
      .vram_rdata_o(vram_rdata));

   // ------------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic acc(input int kind, input logic [7:0] b, output logic [7:0] rd);
      vhp_host_model_inst.access(kind, b, rd);
   endtask

   task automatic reg_wr(input logic [3:0] num, input logic [7:0] val);
      vhp_host_model_inst.cmd_pair(val, {4'h8, num});
   endtask

   // Renderer side read of colour memory, answer one cycle later
   task automatic peek(input logic [4:0] a, input logic [5:0] exp);
      @(posedge clk_i);
      cram_raddr <= a;
      repeat (2) @(posedge clk_i);
      check(16'(cram_rdata), 16'(exp), "colour entry");
   endtask

   task automatic pulse(input logic vb, input logic ln);
      @(posedge clk_i);
      vblank_evt <= vb;
      line_evt   <= ln;
      @(posedge clk_i);
      vblank_evt <= 1'b0;
      line_evt   <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      check(16'(mode_bits), 16'h0010, "mode after reset");
      check(16'(map_base), 16'h3800, "map base after reset");
      check(16'(spr_base), 16'h3F00, "sprite base after reset");
      check(16'(irq_n), 16'h0001, "irq after reset");
   endtask

   task automatic t_regs();
      int ks[3] = '{0, 21, 63};
      reg_wr(4'h0, 8'hE6);
      reg_wr(4'h1, 8'hC2);
      check(16'(mode_bits), 16'h0073, "mode set");
      reg_wr(4'h0, 8'h1E);
      reg_wr(4'h1, 8'h80);
      check(16'(mode_bits), 16'h0008, "mode shift");
      reg_wr(4'h6, 8'hE6);
      reg_wr(4'hF, 8'hE6);
      vhp_host_model_inst.cmd_pair(8'hE6, 8'h90);
      check(16'(mode_bits), 16'h0008, "refused writes");
      for (int i = 0; i < 8; i++) begin
         reg_wr(4'h2, 8'hF1 + 8'(2 * i));
         check(16'(map_base), 16'(i * 2048), "map base");
      end
      foreach (ks[k]) begin
         reg_wr(4'h5, 8'h81 | 8'(ks[k] << 1));
         check(16'(spr_base), 16'(ks[k] << 8), "sprite base");
      end
      reg_wr(4'h3, 8'hFF);
      reg_wr(4'h4, 8'hFF);
   endtask

   task automatic t_vram();
      logic [7:0] d;
      vhp_host_model_inst.cmd_pair(8'hFE, 8'h7F);
      for (int i = 1; i < 4; i++) begin
         acc(2, 8'h11 * 8'(i), d);
      end
      check(16'(vhp_host_model_inst.mem[14'h3FFE]), 16'h0011, "vram wr 0");
      check(16'(vhp_host_model_inst.mem[14'h3FFF]), 16'h0022, "vram wr 1");
      check(16'(vhp_host_model_inst.mem[14'h0000]), 16'h0033, "vram wr 2");
      vhp_host_model_inst.cmd_pair(8'hFE, 8'h3F);
      for (int i = 1; i < 4; i++) begin
         acc(3, 8'h00, d);
         check(16'(d), 16'(8'h11 * 8'(i)), "vram rd back");
      end
      vhp_host_model_inst.cmd_pair(8'h34, 8'h12);
      for (int i = 0; i < 2; i++) begin
         acc(3, 8'h00, d);
         check(16'(d), 16'(8'h34 + 8'(i) ^ 8'h5A), "vram rd");
      end
   endtask

   task automatic t_cram();
      logic [7:0] d;
      vhp_host_model_inst.cmd_pair(8'h1E, 8'hC0);
      acc(2, 8'h15, d);
      acc(2, 8'h2A, d);
      acc(2, 8'hFF, d);
      vhp_host_model_inst.cmd_pair(8'h0F, 8'hC0);
      acc(2, 8'h07, d);
      acc(2, 8'h38, d);
      peek(5'h1E, 6'h15);
      peek(5'h1F, 6'h2A);
      peek(5'h00, 6'h3F);
      peek(5'h0F, 6'h07);
      peek(5'h10, 6'h38);
   endtask

   task automatic t_irq();
      logic [7:0] s;
      reg_wr(4'h0, 8'h16);
      reg_wr(4'h1, 8'h80);
      acc(1, 8'h00, s);
      check(16'(s), 16'h0000, "status not register");
      pulse(1'b1, 1'b0);
      check(16'(irq_n), 16'h0001, "vblank masked");
      acc(1, 8'h00, s);
      check(16'(s), 16'h0080, "vblank status");
      pulse(1'b0, 1'b1);
      check(16'(irq_n), 16'h0000, "line irq");
      acc(1, 8'h00, s);
      check(16'(s), 16'h0040, "line status");
      check(16'(irq_n), 16'h0001, "irq cleared");
      // A status read between the two bytes must not upset the pairing
      acc(0, 8'hA0, s);
      acc(1, 8'h00, s);
      acc(0, 8'h81, s);
      pulse(1'b1, 1'b0);
      check(16'(irq_n), 16'h0000, "vblank enabled");
      acc(1, 8'h00, s);
      check(16'(s), 16'h0080, "vblank only status");
      pulse(1'b1, 1'b1);
      check(16'(irq_n), 16'h0000, "both enabled");
      acc(1, 8'h00, s);
      check(16'(s), 16'h00C0, "both status");
      acc(1, 8'h00, s);
      check(16'(s), 16'h0000, "status cleared");
   endtask

   // ------------------------------------------------------------------
   // Sequence, hang guard and verdict
   // ------------------------------------------------------------------
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run needs about nine hundred cycles of traffic
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         results();
      end
   end

   initial begin
      nrst_i     = 1'b0;
      vblank_evt = 1'b0;
      line_evt   = 1'b0;
      cram_raddr = 5'h00;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_reset();
      t_regs();
      t_vram();
      t_cram();
      t_irq();
      results();
   end
endmodule // vhp_host_port_tb_top
